// >>> rtl/sari_pkg.sv
// Constants shared by the serial result interface design
package sari_pkg;
  localparam int unsigned RESULT_BITS = 16;
  localparam int unsigned FRAME_BITS_SELF = 18;
  localparam int unsigned FRAME_BITS_ECHO = 16;
  localparam logic [1:0] SELF_HEADER = 2'h2;
  localparam int unsigned PIN_COUNT = 8;
  // Pin positions in the synchronised input vector
  localparam int unsigned PIN_CNV_POS = 0;
  localparam int unsigned PIN_CNV_NEG = 1;
  localparam int unsigned PIN_SCLK = 2;
  localparam int unsigned PIN_ECHO = 3;
  localparam int unsigned PIN_SEL0 = 4;
  localparam int unsigned PIN_SEL1 = 5;
  localparam int unsigned PIN_BW = 6;
  localparam int unsigned PIN_CM = 7;
  // Timing
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned CONV_TIME_NS = 100;
  localparam int unsigned CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned STRAP_SETTLE = 3;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PATTERN = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_RESULT = 8'h0C;
  localparam logic [7:0] OFS_COUNT = 8'h10;
  // Field positions
  localparam int unsigned CTRL_USE_PATTERN = 0;
  localparam int unsigned ST_ECHOED = 0;
  localparam int unsigned ST_BUSY = 1;
  localparam int unsigned ST_SHIFTING = 2;
  localparam int unsigned ST_BW_NARROW = 3;
  localparam int unsigned ST_CM_EN = 4;
  localparam int unsigned ST_REFBUF_EN = 5;
  localparam int unsigned ST_CNV_DIFF = 6;
  localparam int unsigned ST_STRAP_DONE = 7;
  // Reset values
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [15:0] PATTERN_RESET = 16'h0000;
  typedef enum logic [1:0] {
    SARI_IDLE = 2'h0,
    SARI_CONVERT = 2'h1,
    SARI_SHIFT = 2'h2
  } sari_state_type;
endpackage : sari_pkg

// >>> rtl/sari_sync.sv
// Two-flop synchroniser bank for asynchronous pin inputs
`timescale 1ns/1ps
`default_nettype none
module sari_sync #(
  parameter int unsigned WIDTH = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_r;

  if (WIDTH < 1) begin : g_width_check
    $error("sari_sync: WIDTH must be at least 1");
  end

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_r <= '0;
      sync_out <= '0;
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule : sari_sync
`default_nettype wire

// >>> rtl/sari_top.sv
// Convert control and serial result interface of a 16-bit sampling converter
`timescale 1ns/1ps
`default_nettype none
module sari_top
  import sari_pkg::*;
#(
  parameter int unsigned CONV_CYC = CONV_CYCLES
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic convert_start_pos,
  input wire logic convert_start_neg,
  input wire logic shift_clock_pos,
  input wire logic echo_clock_out_pos_in,
  output logic echo_clock_out_pos_out,
  output logic echo_clock_out_pos_oe,
  output logic echo_clock_out_neg,
  output logic data_out_pos,
  output logic data_out_neg,
  input wire logic operation_select_0,
  input wire logic operation_select_1,
  input wire logic bandwidth_select,
  input wire logic common_mode_out_enable,
  output logic bandwidth_narrow,
  output logic common_mode_voltage_out,
  output logic reference_buffer_enable,
  input wire logic [RESULT_BITS-1:0] core_result,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp
);
  localparam int unsigned CNT_W = $clog2(CONV_CYC + 1);

  if (CONV_CYC < 1) begin : g_conv_check
    $error("sari_top: CONV_CYC must be at least 1");
  end

  logic [PIN_COUNT-1:0] pins_s;
  sari_sync #(.WIDTH(PIN_COUNT)) u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .async_in({common_mode_out_enable, bandwidth_select, operation_select_1, operation_select_0,
               echo_clock_out_pos_in, shift_clock_pos, convert_start_neg, convert_start_pos}),
    .sync_out(pins_s)
  );

  sari_state_type state_r, state_nxt;
  logic cnv_prev_r, sclk_prev_r, echo_r, data_r, echoed_r, strap_done_r;
  logic [1:0] settle_r;
  logic [CNT_W-1:0] conv_cnt_r;
  logic [FRAME_BITS_SELF-1:0] shreg_r;
  logic [4:0] bits_left_r;
  logic [RESULT_BITS-1:0] sample_r, result_r, pattern_r;
  logic [31:0] ctrl_r, count_r, hrdata_r;
  logic bw_r, cm_r, refbuf_r;
  logic wr_pend_r;
  logic [7:0] addr_r;

  // Convert input signalling and edge
  wire cnv_single = ~pins_s[PIN_CNV_NEG];
  wire cnv_level = cnv_single ? pins_s[PIN_CNV_POS]
                              : (pins_s[PIN_CNV_POS] & ~pins_s[PIN_CNV_NEG]);
  wire cnv_rise = cnv_level & ~cnv_prev_r;
  wire sclk_fall = sclk_prev_r & ~pins_s[PIN_SCLK];
  wire conv_done = (state_r == SARI_CONVERT) && (conv_cnt_r == CNT_W'(CONV_CYC - 1)) && !cnv_rise;
  wire shift_now = sclk_fall && (bits_left_r != 5'h00);
  wire strap_take = !strap_done_r && (settle_r == 2'(STRAP_SETTLE - 1));
  wire [RESULT_BITS-1:0] sample_src = ctrl_r[CTRL_USE_PATTERN] ? pattern_r : core_result;
  wire [4:0] frame_len = echoed_r ? 5'(FRAME_BITS_ECHO) : 5'(FRAME_BITS_SELF);
  wire [RESULT_BITS-1:0] result_nxt_w = sample_r;
  wire [FRAME_BITS_SELF-1:0] frame_word = echoed_r ? {result_nxt_w, 2'h0} : {SELF_HEADER, result_nxt_w};

  // Next state
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      SARI_IDLE: if (cnv_rise) state_nxt = SARI_CONVERT;
      SARI_CONVERT: if (conv_done) state_nxt = SARI_SHIFT;
      SARI_SHIFT: begin
        if (cnv_rise) begin
          state_nxt = SARI_CONVERT;
        end else if (bits_left_r == 5'h00) begin
          state_nxt = SARI_IDLE;
        end
      end
      default: state_nxt = SARI_IDLE;
    endcase
    if (cnv_rise) state_nxt = SARI_CONVERT;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= SARI_IDLE;
      cnv_prev_r <= 1'b0;
      sclk_prev_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnv_prev_r <= cnv_level;
      sclk_prev_r <= pins_s[PIN_SCLK];
    end
  end

  // Sampling and conversion timer
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      conv_cnt_r <= '0;
      sample_r <= '0;
      result_r <= '0;
      count_r <= '0;
    end else if (cnv_rise) begin
      conv_cnt_r <= '0;
      sample_r <= sample_src;
      count_r <= count_r + 32'h1;
    end else if (state_r == SARI_CONVERT) begin
      conv_cnt_r <= conv_cnt_r + CNT_W'(1);
      if (conv_done) result_r <= sample_r;
    end
  end

  // Mode strap caught after reset release, pin undriven meanwhile
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      settle_r <= 2'h0;
      strap_done_r <= 1'b0;
      echoed_r <= 1'b0;
    end else if (strap_take) begin
      strap_done_r <= 1'b1;
      echoed_r <= pins_s[PIN_ECHO];
    end else if (!strap_done_r) begin
      settle_r <= settle_r + 2'h1;
    end
  end

  // Output shifter; falls beyond the frame leave it idle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      shreg_r <= '0;
      bits_left_r <= 5'h00;
      data_r <= 1'b0;
    end else if (cnv_rise) begin
      bits_left_r <= 5'h00;
    end else if (conv_done) begin
      shreg_r <= frame_word;
      bits_left_r <= frame_len;
      data_r <= 1'b0;
    end else if (shift_now) begin
      data_r <= shreg_r[FRAME_BITS_SELF-1];
      shreg_r <= {shreg_r[FRAME_BITS_SELF-2:0], 1'b0};
      bits_left_r <= bits_left_r - 5'h01;
    end
  end

  // Echo clock moves in the same cycle as the data, so data changes on its fall
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      echo_r <= 1'b0;
    end else begin
      echo_r <= pins_s[PIN_SCLK];
    end
  end

  // Static configuration pins
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bw_r <= 1'b0;
      cm_r <= 1'b0;
      refbuf_r <= 1'b0;
    end else begin
      bw_r <= pins_s[PIN_BW];
      cm_r <= pins_s[PIN_CM];
      refbuf_r <= pins_s[PIN_SEL0] & ~pins_s[PIN_SEL1];
    end
  end

  assign echo_clock_out_pos_oe = strap_done_r & echoed_r;
  assign echo_clock_out_pos_out = echo_r & echoed_r;
  assign echo_clock_out_neg = ~(echo_r & echoed_r);
  assign data_out_pos = data_r;
  assign data_out_neg = ~data_r;
  assign bandwidth_narrow = bw_r;
  assign common_mode_voltage_out = cm_r;
  assign reference_buffer_enable = refbuf_r;

  // AHB-Lite slave, zero wait states, always OKAY
  wire addr_phase = hsel && hready && htrans[1];
  wire [31:0] status_w = {24'h0, strap_done_r, ~cnv_single, refbuf_r, cm_r, bw_r,
                          (bits_left_r != 5'h00), (state_r == SARI_CONVERT), echoed_r};
  wire [7:0] raddr = haddr[7:0];
  wire [31:0] rd_mux = (haddr[31:8] != 24'h0) ? 32'h0 :
                       (raddr == OFS_CTRL) ? ctrl_r :
                       (raddr == OFS_PATTERN) ? {16'h0, pattern_r} :
                       (raddr == OFS_STATUS) ? status_w :
                       (raddr == OFS_RESULT) ? {16'h0, result_r} :
                       (raddr == OFS_COUNT) ? count_r : 32'h0;

  // Read data taken at the address phase, so it stands through the data phase
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_pend_r <= 1'b0;
      addr_r <= 8'h00;
      hrdata_r <= 32'h0;
    end else begin
      wr_pend_r <= addr_phase && hwrite && (haddr[31:8] == 24'h0) && (hsize == 3'h2);
      if (addr_phase) begin
        addr_r <= raddr;
        hrdata_r <= hwrite ? 32'h0 : rd_mux;
      end
    end
  end

  // Write data follows its address phase by one cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_r <= CTRL_RESET;
      pattern_r <= PATTERN_RESET;
    end else if (wr_pend_r) begin
      if (addr_r == OFS_CTRL) ctrl_r <= {31'h0, hwdata[CTRL_USE_PATTERN]};
      if (addr_r == OFS_PATTERN) pattern_r <= hwdata[15:0];
    end
  end

  assign hrdata = hrdata_r;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Checks
  cnv_start_a: assert property (@(posedge clk) disable iff (!rst_b)
    cnv_rise |=> state_r == SARI_CONVERT && sample_r == $past(sample_src) && conv_cnt_r == '0)
    else $error("convert edge did not start a conversion");
  cnv_single_a: assert property (@(posedge clk) disable iff (!rst_b)
    !pins_s[PIN_CNV_NEG] && pins_s[PIN_CNV_POS] && !cnv_prev_r |-> cnv_rise)
    else $error("single-ended convert edge missed");
  mode_strap_a: assert property (@(posedge clk) disable iff (!rst_b)
    strap_take |=> strap_done_r && echoed_r == $past(pins_s[PIN_ECHO]) && echo_clock_out_pos_oe == echoed_r)
    else $error("interface mode not taken from strap");
  self_frame_a: assert property (@(posedge clk) disable iff (!rst_b)
    conv_done && !echoed_r |=> data_r == 1'b0 && shreg_r[17:16] == 2'h2 && bits_left_r == 5'h12)
    else $error("self-clocked frame header wrong");
  echo_copy_a: assert property (@(posedge clk) disable iff (!rst_b)
    echoed_r |=> echo_clock_out_pos_out == $past(pins_s[PIN_SCLK]))
    else $error("echo clock is not a copy of shift clock");
  data_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
    !shift_now && !conv_done |=> $stable(data_r))
    else $error("data changed away from a shift clock fall");
  shift_bit_a: assert property (@(posedge clk) disable iff (!rst_b)
    shift_now && !cnv_rise |=> data_r == $past(shreg_r[17]) && bits_left_r == $past(bits_left_r) - 5'h01)
    else $error("shift clock fall did not advance data");
  echo_len_a: assert property (@(posedge clk) disable iff (!rst_b)
    conv_done && echoed_r |=> bits_left_r == 5'h10 && shreg_r[17:2] == $past(sample_r))
    else $error("echoed frame length or order wrong");
  cfg_pins_a: assert property (@(posedge clk) disable iff (!rst_b)
    1'b1 |=> bandwidth_narrow == $past(pins_s[PIN_BW]) && common_mode_voltage_out == $past(pins_s[PIN_CM]))
    else $error("static configuration not followed");
  conv_len_a: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(state_r == SARI_CONVERT) |-> ##[1:300] (state_r != SARI_CONVERT || cnv_rise))
    else $error("conversion never ended");
  cfg_ref_a: assert property (@(posedge clk) disable iff (!rst_b)
    1'b1 |=> reference_buffer_enable == $past(pins_s[PIN_SEL0] & ~pins_s[PIN_SEL1]))
    else $error("reference buffer select not followed");
  echo_idle_a: assert property (@(posedge clk) disable iff (!rst_b)
    !echoed_r |-> !echo_clock_out_pos_oe && !echo_clock_out_pos_out)
    else $error("strapped echo pin driven in self-clocked mode");
  result_load_a: assert property (@(posedge clk) disable iff (!rst_b)
    conv_done |=> result_r == $past(sample_r))
    else $error("result not kept at conversion end");
  extra_fall_a: assert property (@(posedge clk) disable iff (!rst_b)
    sclk_fall && bits_left_r == 5'h00 && !conv_done |=> $stable(shreg_r) && $stable(data_r))
    else $error("shift clock fall beyond the frame moved data");
  frame_end_a: assert property (@(posedge clk) disable iff (!rst_b)
    state_r == SARI_SHIFT && bits_left_r == 5'h00 && !cnv_rise |=> state_r == SARI_IDLE)
    else $error("frame did not end after its last bit");

  conv_c: cover property (@(posedge clk) disable iff (!rst_b) conv_done);
  self_frame_c: cover property (@(posedge clk) disable iff (!rst_b)
    !echoed_r && shift_now && bits_left_r == 5'h01);
  echo_frame_c: cover property (@(posedge clk) disable iff (!rst_b)
    echoed_r && shift_now && bits_left_r == 5'h01);
  bus_write_c: cover property (@(posedge clk) disable iff (!rst_b) wr_pend_r && addr_r == OFS_CTRL);
  strap_c: cover property (@(posedge clk) disable iff (!rst_b) strap_take && pins_s[PIN_ECHO]);
endmodule : sari_top
`default_nettype wire

// >>> dv/sari_host.sv
// Host model: drives convert and shift clock, captures serial result
`timescale 1ns/1ps
`default_nettype none
module sari_host (
  input wire logic clk,
  output var logic convert_start_pos,
  output var logic shift_clock_pos,
  input wire logic echo_clock_pos,
  input wire logic data_out_pos
);
  // Shift clock parked high so the first falling edge of a burst is real
  initial begin
    convert_start_pos = 1'b0;
    shift_clock_pos = 1'b1;
  end

  task automatic start_conv();
    @(posedge clk);
    convert_start_pos <= 1'b1;
    repeat (4) @(posedge clk);
    convert_start_pos <= 1'b0;
  endtask : start_conv

  // 160 ns link period: four clocks low, four high
  task automatic read_frame(input int n, input logic echoed, output logic [17:0] w);
    w = 18'h0;
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      shift_clock_pos <= 1'b0;
      repeat (4) @(posedge clk);
      shift_clock_pos <= 1'b1;
      // Echoed mode captures on the echo rise, self mode just before the next fall
      if (echoed) @(posedge echo_clock_pos);
      else repeat (3) @(posedge clk);
      w = {w[16:0], data_out_pos};
    end
  endtask : read_frame
endmodule : sari_host
`default_nettype wire

// >>> dv/testbench.sv
// Self-checking bench for the serial result interface
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import sari_pkg::*;
  logic clk, rst_b, cnv_neg, echo_strap, sel0, sel1, bw, cm, hsel, hwrite;
  logic [15:0] core_result;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [17:0] w;
  wire logic cnv_pos, sclk, echo_out, echo_oe, echo_neg, dpos, dneg, bw_n, cm_o, refb, hreadyout, hresp;
  // Echo pin floats to its strap level unless the device drives it
  wire logic echo_pin = echo_oe ? echo_out : echo_strap;
  int errors, tests_run;
  int cyc = 0;

  sari_host host (.clk(clk), .convert_start_pos(cnv_pos), .shift_clock_pos(sclk),
    .echo_clock_pos(echo_out), .data_out_pos(dpos));

  sari_top dut (.clk(clk), .rst_b(rst_b), .convert_start_pos(cnv_pos), .convert_start_neg(cnv_neg),
    .shift_clock_pos(sclk), .echo_clock_out_pos_in(echo_pin), .echo_clock_out_pos_out(echo_out),
    .echo_clock_out_pos_oe(echo_oe), .echo_clock_out_neg(echo_neg), .data_out_pos(dpos),
    .data_out_neg(dneg), .operation_select_0(sel0), .operation_select_1(sel1),
    .bandwidth_select(bw), .common_mode_out_enable(cm), .bandwidth_narrow(bw_n),
    .common_mode_voltage_out(cm_o), .reference_buffer_enable(refb), .core_result(core_result),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic finish_test();
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : finish_test

  // Generous ceiling; the whole sequence needs about 550 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      finish_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      errors++;
    end
  endtask : chk

  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : ahb

  task automatic rchk(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0, rd);
    chk(rd & mask, exp);
  endtask : rchk

  task automatic do_reset(input logic strap);
    echo_strap <= strap;
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    repeat (6) @(posedge clk);
  endtask : do_reset

  initial begin
    {errors, tests_run} = '0;
    {rst_b, cnv_neg, echo_strap, sel0, sel1, bw, cm, hsel, hwrite} = '0;
    {core_result, haddr, hwdata, htrans} = '0;
    hsize = 3'h2;
    repeat (2) @(posedge clk);
    chk({echo_neg, dneg, hreadyout, hresp, echo_oe}, 32'h1C);
    rst_b <= 1'b1;
    repeat (6) @(posedge clk);
    // Self-clocked mode: echo pin grounded
    rchk(OFS_STATUS, 32'h81, 32'h80);
    chk(echo_oe, 1'b0);
    ahb(1'b1, OFS_PATTERN, 32'hA5C3, rd);
    ahb(1'b1, OFS_CTRL, 32'h1, rd);
    rchk(OFS_PATTERN, 32'hFFFF, 32'hA5C3);
    host.start_conv();
    repeat (12) @(posedge clk);
    chk(dpos, 1'b0);
    host.read_frame(18, 1'b0, w);
    chk(w[17:16], 2'h2);
    chk(w[15:0], 16'hA5C3);
    rchk(OFS_COUNT, 32'hFFFF, 32'h1);
    // High negative pin keeps the differential level low
    cnv_neg <= 1'b1;
    host.start_conv();
    repeat (12) @(posedge clk);
    rchk(OFS_COUNT, 32'hFFFF, 32'h1);
    rchk(OFS_STATUS, 32'h40, 32'h40);
    chk(dpos, 1'b1);
    cnv_neg <= 1'b0;
    host.start_conv();
    repeat (12) @(posedge clk);
    rchk(OFS_COUNT, 32'hFFFF, 32'h2);
    chk({dpos, dneg}, 2'h1);
    for (int i = 0; i < 16; i++) begin
      {sel1, sel0, cm, bw} <= i[3:0];
      repeat (6) @(posedge clk);
      chk(bw_n, i[0]);
      chk(cm_o, i[1]);
      chk(refb, i[2] & ~i[3]);
      rchk(OFS_STATUS, 32'h38, {26'h0, i[2] & ~i[3], i[1], i[0], 3'h0});
    end
    rchk(8'h20, 32'hFFFFFFFF, 32'h0);
    ahb(1'b1, OFS_RESULT, 32'hFFFF, rd);
    rchk(OFS_RESULT, 32'hFFFF, 32'hA5C3);
    // Echoed-clock mode: pin left high through the strap window
    do_reset(1'b1);
    rchk(OFS_STATUS, 32'h1, 32'h1);
    chk({echo_oe, echo_out, echo_neg}, 3'h6);
    rchk(OFS_CTRL, 32'hFFFFFFFF, CTRL_RESET);
    rchk(OFS_PATTERN, 32'hFFFF, {16'h0, PATTERN_RESET});
    core_result <= 16'h3C96;
    host.start_conv();
    repeat (12) @(posedge clk);
    host.read_frame(16, 1'b1, w);
    chk(w[15:0], 16'h3C96);
    rchk(OFS_RESULT, 32'hFFFF, 32'h3C96);
    finish_test();
  end
endmodule : testbench
`default_nettype wire
